/* File: rtl/pshm_pkg.sv */
// Contract
// - Free-run off: no sentence trigger until an external pulse arrived.
// - Free-run on: unsynchronised sentence trigger runs from reset.
// - An external pulse realigns the sentence trigger to it.
// - Free-run option resets to disabled.
// - Pulse output free until third external pulse, then phase-aligned.
// - Pulse output and trigger keep running when the reference vanishes.
// - Health word: one bit per fault, value is OR of active faults.
// - Lock mode and phase offset above 250 ns sets health bit 0x4.
// - Oscillator control voltage too high sets health bit 0x40.
// - Holdover sets health bit 0x10.
// - Health reads zero only when warm, locked and fault free.
// - Pulse offset measured and reported in units of 1E-10 s.
// - Oscillator loop lock reported as one bit, 0 off, 1 on.
// - Frequency error from offset change over 1000 s.
// - Serial link is 8 data bits, 1 stop, no parity, no flow control.
// - Baud selectable 9600..115200, restore gives 115200.
// - Switchable echo of received characters.
// - Switchable prompt string at start of each command line.
// - Fast loop bandwidth narrow, medium or wide; narrow by default.
// - Oscillator control reported as relative -100..+100 percent.
// - Oscillator control reported as absolute 0..5 V.
// - Powered-on hours counted and readable.
// - Restore command rewrites defaults and requests storage overwrite.
package pshm_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int PHASE_LIMIT_NS = 250;
   localparam int PHASE_LIMIT_CYC = PHASE_LIMIT_NS / CLK_PERIOD_NS;
   localparam int TINT_RES_PS = 100;
   localparam int TINT_PER_CYC = CLK_PERIOD_NS * 1000 / TINT_RES_PS;
   localparam int FE_INTERVAL_S = 1000;
   localparam int HOUR_S = 3600;
   localparam int PPS_WIDTH_NS = 1000;
   localparam int PPS_WIDTH_CYC = PPS_WIDTH_NS / CLK_PERIOD_NS;
   localparam logic [1:0] SYNC_PULSES = 2'h3;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int DIV_W = 16;
   localparam int HEALTH_W = 18;
   localparam int EFC_W = 16;
   localparam int EFC_REL_SPAN = 200;
   localparam int EFC_REL_OFS = 100;
   localparam int EFC_FULL_MV = 5000;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_CMD = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] REG_HEALTH = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_TINT = 8'h10;
   localparam logic [ADDR_W-1:0] REG_FREQ_ERR = 8'h14;
   localparam logic [ADDR_W-1:0] REG_EFC_REL = 8'h18;
   localparam logic [ADDR_W-1:0] REG_EFC_ABS = 8'h1C;
   localparam logic [ADDR_W-1:0] REG_HOURS = 8'h20;
   localparam logic [ADDR_W-1:0] REG_TXDATA = 8'h24;
   localparam logic [ADDR_W-1:0] REG_RXDATA = 8'h28;
   localparam int CB_FREE = 0;
   localparam int CB_ECHO = 1;
   localparam int CB_PROMPT = 2;
   localparam int CB_BW = 3;
   localparam int CB_BAUD = 5;
   localparam int CMD_RESTORE = 0;
   localparam int HB_WARMUP = 0;
   localparam int HB_UNLOCK = 1;
   localparam int HB_PHASE = 2;
   localparam int HB_HOLD = 4;
   localparam int HB_EFC = 6;
   localparam logic FREE_RST = 1'b0;
   localparam logic ECHO_RST = 1'b1;
   localparam logic PROMPT_RST = 1'b1;
   localparam logic [2:0] BAUD_SEL_RST = 3'h4;
   localparam logic [2:0] BAUD_SEL_MAX = 3'h4;
   localparam logic [3:0] FRAME_BITS = 4'hA;
   localparam logic [7:0] CHAR_CR = 8'h0D;
   localparam logic [2:0] PROMPT_LEN = 3'h5;
   typedef enum logic [1:0] {BW_NARROW, BW_MEDIUM, BW_WIDE} pshm_bw_t;
   typedef enum logic [1:0] {ST_WAIT, ST_COUNT, ST_SYNCED} pshm_sync_t;

   function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] sel);
      case (sel)
         3'h0: baud_div = DIV_W'(CLK_HZ / 9600);
         3'h1: baud_div = DIV_W'(CLK_HZ / 19200);
         3'h2: baud_div = DIV_W'(CLK_HZ / 38400);
         3'h3: baud_div = DIV_W'(CLK_HZ / 57600);
         default: baud_div = DIV_W'(CLK_HZ / 115200);
      endcase
   endfunction : baud_div

   function automatic logic [7:0] prompt_char(input logic [2:0] idx);
      case (idx)
         3'h0: prompt_char = 8'h73;
         3'h1: prompt_char = 8'h63;
         3'h2: prompt_char = 8'h70;
         3'h3: prompt_char = 8'h69;
         default: prompt_char = 8'h3E;
      endcase
   endfunction : prompt_char
endpackage : pshm_pkg

/* File: rtl/pshm_uart_if.sv */
`timescale 1ns/1ps
interface pshm_uart_if;
   import pshm_pkg::*;
   logic ce;
   logic [DIV_W-1:0] div;
   logic tx_start;
   logic [7:0] tx_data;
   logic tx_busy;
   logic rx_valid;
   logic [7:0] rx_data;
   logic rx_lvl;
   logic tx_pin;
   modport core (output ce, div, tx_start, tx_data, rx_lvl,
                 input tx_busy, rx_valid, rx_data, tx_pin);
   modport phy (input ce, div, tx_start, tx_data, rx_lvl,
                output tx_busy, rx_valid, rx_data, tx_pin);
endinterface : pshm_uart_if

/* File: rtl/pshm_uart.sv */
`timescale 1ns/1ps
module pshm_uart (
   input wire logic mclk,
   input wire logic rst,
   pshm_uart_if.phy u
);
   import pshm_pkg::*;
   typedef enum logic {TX_IDLE, TX_SHIFT} pshm_tx_t;
   typedef enum logic {RX_IDLE, RX_DATA} pshm_rx_t;
   pshm_tx_t tx_st_ff;
   pshm_rx_t rx_st_ff;
   logic [9:0] tx_sh_ff;
   logic [3:0] tx_bits_ff, rx_bits_ff;
   logic [DIV_W-1:0] tx_tmr_ff, rx_tmr_ff;
   logic [7:0] rx_sh_ff, rx_data_ff;
   logic tx_pin_ff, rx_valid_ff;

   assign u.tx_busy = (tx_st_ff != TX_IDLE);
   assign u.tx_pin = tx_pin_ff;
   assign u.rx_valid = rx_valid_ff;
   assign u.rx_data = rx_data_ff;

   // start, 8 data lsb first, stop; no parity bit exists
   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_st_ff <= TX_IDLE;
         tx_sh_ff <= 10'h3FF;
         tx_bits_ff <= 4'h0;
         tx_tmr_ff <= '0;
         tx_pin_ff <= 1'b1;
      end else if (u.ce) begin
         case (tx_st_ff)
            TX_IDLE: begin
               if (u.tx_start) begin
                  tx_sh_ff <= {1'b1, u.tx_data, 1'b0};
                  tx_bits_ff <= FRAME_BITS;
                  tx_tmr_ff <= '0;
                  tx_st_ff <= TX_SHIFT;
               end
            end
            default: begin
               if (tx_tmr_ff != '0) begin
                  tx_tmr_ff <= tx_tmr_ff - 1'b1;
               end else if (tx_bits_ff == 4'h0) begin
                  tx_st_ff <= TX_IDLE;
               end else begin
                  tx_pin_ff <= tx_sh_ff[0];
                  tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
                  tx_bits_ff <= tx_bits_ff - 1'b1;
                  tx_tmr_ff <= u.div - 1'b1;
               end
            end
         endcase
      end
   end

   // first sample mid start bit rejects glitches
   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_st_ff <= RX_IDLE;
         rx_bits_ff <= 4'h0;
         rx_tmr_ff <= '0;
         rx_sh_ff <= 8'h00;
         rx_data_ff <= 8'h00;
         rx_valid_ff <= 1'b0;
      end else if (u.ce) begin
         rx_valid_ff <= 1'b0;
         case (rx_st_ff)
            RX_IDLE: begin
               if (!u.rx_lvl) begin
                  rx_tmr_ff <= {1'b0, u.div[DIV_W-1:1]};
                  rx_bits_ff <= FRAME_BITS;
                  rx_st_ff <= RX_DATA;
               end
            end
            default: begin
               if (rx_tmr_ff != '0) begin
                  rx_tmr_ff <= rx_tmr_ff - 1'b1;
               end else begin
                  rx_tmr_ff <= u.div - 1'b1;
                  rx_bits_ff <= rx_bits_ff - 1'b1;
                  if (rx_bits_ff == FRAME_BITS) begin
                     if (u.rx_lvl) begin
                        rx_st_ff <= RX_IDLE;
                     end
                  end else if (rx_bits_ff == 4'h1) begin
                     rx_st_ff <= RX_IDLE;
                     rx_valid_ff <= u.rx_lvl;
                     rx_data_ff <= rx_sh_ff;
                  end else begin
                     rx_sh_ff <= {u.rx_lvl, rx_sh_ff[7:1]};
                  end
               end
            end
         endcase
      end
   end
endmodule : pshm_uart

/* File: rtl/pshm_top.sv */
`timescale 1ns/1ps
module pshm_top #(
   parameter int SEC_CYCLES = pshm_pkg::CLK_HZ
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [pshm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pshm_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [pshm_pkg::DATA_W-1:0] reg_rdata,
   input wire logic ext_pps_pin,
   input wire logic ser_rx_pin,
   output logic ser_tx_pin,
   output logic pps_out,
   output logic sentence_trig,
   input wire logic warmup_done,
   input wire logic osc_loop_locked,
   input wire logic holdover_active,
   input wire logic efc_too_high,
   input wire logic pps_lock_mode,
   input wire logic [pshm_pkg::EFC_W-1:0] osc_control_output,
   output pshm_pkg::pshm_bw_t fast_osc_loop_bandwidth,
   output logic nvm_restore
);
   import pshm_pkg::*;
   localparam int CW = $clog2(SEC_CYCLES);
   localparam int TW = (CW + 9 > DATA_W) ? CW + 9 : DATA_W + 1;
   localparam logic [CW-1:0] SEC_LAST = CW'(SEC_CYCLES - 1);
   localparam logic [CW-1:0] SEC_HALF = CW'(SEC_CYCLES / 2);
   localparam logic [CW:0] SEC_FULL = (CW + 1)'(SEC_CYCLES);
   localparam logic [CW-1:0] PPS_HIGH = CW'(PPS_WIDTH_CYC);
   localparam logic [CW:0] PHASE_LIM = (CW + 1)'(PHASE_LIMIT_CYC);
   localparam logic signed [8:0] TINT_K = 9'(TINT_PER_CYC);
   localparam logic signed [TW-1:0] T_MAX = TW'(32'sh7FFFFFFF);
   localparam logic signed [TW-1:0] T_MIN = TW'(32'sh80000000);
   localparam logic [9:0] FE_LAST = 10'(FE_INTERVAL_S - 1);
   localparam logic [11:0] HOUR_LAST = 12'(HOUR_S - 1);
   localparam logic [EFC_W+7:0] REL_K = (EFC_W + 8)'(EFC_REL_SPAN);
   localparam logic [7:0] REL_OFS = 8'(EFC_REL_OFS);
   localparam logic [EFC_W+12:0] ABS_K = (EFC_W + 13)'(EFC_FULL_MV);

   pshm_uart_if u ();

   pshm_uart uart_i (
      .mclk(mclk),
      .rst(rst),
      .u(u)
   );

   // pin synchronisers; stage one feeds only stage two
   logic pps_s1_ff, pps_s2_ff, pps_s3_ff, pps_lvl_ff;
   logic rx_s1_ff, rx_s2_ff, rx_s3_ff, rx_lvl_ff;
   logic ext_edge;

   always_ff @(posedge mclk) begin
      if (rst) begin
         pps_s1_ff <= 1'b0;
         pps_s2_ff <= 1'b0;
         pps_s3_ff <= 1'b0;
         pps_lvl_ff <= 1'b0;
         rx_s1_ff <= 1'b1;
         rx_s2_ff <= 1'b1;
         rx_s3_ff <= 1'b1;
         rx_lvl_ff <= 1'b1;
      end else if (ce) begin
         pps_s1_ff <= ext_pps_pin;
         pps_s2_ff <= pps_s1_ff;
         pps_s3_ff <= pps_s2_ff;
         rx_s1_ff <= ser_rx_pin;
         rx_s2_ff <= rx_s1_ff;
         rx_s3_ff <= rx_s2_ff;
         if (pps_s2_ff == pps_s3_ff) begin
            pps_lvl_ff <= pps_s3_ff;
         end
         if (rx_s2_ff == rx_s3_ff) begin
            rx_lvl_ff <= rx_s3_ff;
         end
      end
   end

   assign ext_edge = ce & pps_s2_ff & pps_s3_ff & ~pps_lvl_ff;

   // configuration
   logic free_run_ff, echo_en_ff, prompt_en_ff;
   logic [2:0] baud_sel_ff;
   pshm_bw_t bw_ff;
   logic restore_ff;
   logic wr_ctrl, wr_cmd, wr_tx, rd_rx;

   assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
   assign wr_cmd = reg_wr && (reg_addr == REG_CMD) && reg_wdata[CMD_RESTORE];
   assign wr_tx = reg_wr && (reg_addr == REG_TXDATA);
   assign rd_rx = reg_rd && (reg_addr == REG_RXDATA);

   always_ff @(posedge mclk) begin
      if (rst || (ce && wr_cmd)) begin
         free_run_ff <= FREE_RST;
         echo_en_ff <= ECHO_RST;
         prompt_en_ff <= PROMPT_RST;
         baud_sel_ff <= BAUD_SEL_RST;
         bw_ff <= BW_NARROW;
      end else if (ce && wr_ctrl) begin
         free_run_ff <= reg_wdata[CB_FREE];
         echo_en_ff <= reg_wdata[CB_ECHO];
         prompt_en_ff <= reg_wdata[CB_PROMPT];
         // unsupported codes leave the setting alone
         if (reg_wdata[CB_BW+1:CB_BW] <= 2'(BW_WIDE)) begin
            bw_ff <= pshm_bw_t'(reg_wdata[CB_BW+1:CB_BW]);
         end
         if (reg_wdata[CB_BAUD+2:CB_BAUD] <= BAUD_SEL_MAX) begin
            baud_sel_ff <= reg_wdata[CB_BAUD+2:CB_BAUD];
         end
      end
   end

   // one-cycle request to the storage controller
   always_ff @(posedge mclk) begin
      if (rst) begin
         restore_ff <= 1'b0;
      end else if (ce) begin
         restore_ff <= wr_cmd;
      end
   end

   assign nvm_restore = restore_ff;
   assign fast_osc_loop_bandwidth = bw_ff;

   // synchronisation state
   pshm_sync_t sync_st_ff;
   logic [1:0] ext_cnt_ff;
   logic align;

   assign align = ext_edge && (sync_st_ff == ST_SYNCED ||
                               ext_cnt_ff == SYNC_PULSES - 2'h1);

   always_ff @(posedge mclk) begin
      if (rst) begin
         sync_st_ff <= ST_WAIT;
         ext_cnt_ff <= 2'h0;
      end else if (ext_edge) begin
         if (ext_cnt_ff != SYNC_PULSES) begin
            ext_cnt_ff <= ext_cnt_ff + 2'h1;
         end
         case (sync_st_ff)
            ST_WAIT: sync_st_ff <= ST_COUNT;
            ST_COUNT: begin
               if (align) begin
                  sync_st_ff <= ST_SYNCED;
               end
            end
            default: sync_st_ff <= ST_SYNCED;
         endcase
      end
   end

   // sentence trigger and pulse output timebases wrap each second; ext_edge and align restart them
   logic [CW-1:0] trig_cnt_ff, pps_cnt_ff;
   logic trig_ff, pps_ff, trig_run, trig_wrap, pps_wrap;

   assign trig_wrap = (trig_cnt_ff == SEC_LAST);
   assign pps_wrap = (pps_cnt_ff == SEC_LAST);
   assign trig_run = free_run_ff || (sync_st_ff != ST_WAIT) || ext_edge;

   always_ff @(posedge mclk) begin
      if (rst) begin
         trig_cnt_ff <= '0;
         trig_ff <= 1'b0;
      end else if (ce) begin
         if (ext_edge || trig_wrap) begin
            trig_cnt_ff <= '0;
         end else begin
            trig_cnt_ff <= trig_cnt_ff + 1'b1;
         end
         trig_ff <= trig_run && (ext_edge || trig_wrap);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pps_cnt_ff <= '0;
         pps_ff <= 1'b0;
      end else if (ce) begin
         if (align || pps_wrap) begin
            pps_cnt_ff <= '0;
            pps_ff <= 1'b1;
         end else begin
            pps_cnt_ff <= pps_cnt_ff + 1'b1;
            pps_ff <= (pps_cnt_ff + 1'b1) < PPS_HIGH;
         end
      end
   end

   assign sentence_trig = trig_ff;
   assign pps_out = pps_ff;

   // offset: positive when the own pulse came first
   logic signed [CW:0] offset;
   logic [CW:0] offset_mag;
   logic signed [TW-1:0] tint_wide;
   logic signed [DATA_W-1:0] tint_sat;

   always_comb begin
      if (pps_cnt_ff < SEC_HALF) begin
         offset = $signed({1'b0, pps_cnt_ff});
      end else begin
         offset = $signed({1'b0, pps_cnt_ff}) - $signed(SEC_FULL);
      end
      offset_mag = (offset < 0) ? (CW + 1)'(-offset) : (CW + 1)'(offset);
      tint_wide = TW'(offset) * TW'(TINT_K);
      if (tint_wide > T_MAX) begin
         tint_sat = 32'sh7FFFFFFF;
      end else if (tint_wide < T_MIN) begin
         tint_sat = 32'sh80000000;
      end else begin
         tint_sat = tint_wide[DATA_W-1:0];
      end
   end

   logic signed [DATA_W-1:0] tint_ff, tint_ref_ff, freq_err_ff;
   logic [9:0] fe_cnt_ff;
   logic phase_bad_ff;

   always_ff @(posedge mclk) begin
      if (rst) begin
         tint_ff <= '0;
         phase_bad_ff <= 1'b0;
      end else if (ext_edge) begin
         tint_ff <= tint_sat;
         phase_bad_ff <= offset_mag > PHASE_LIM;
      end
   end

   // offset change across the window; software divides by its length
   always_ff @(posedge mclk) begin
      if (rst) begin
         tint_ref_ff <= '0;
         freq_err_ff <= '0;
         fe_cnt_ff <= '0;
      end else if (ext_edge) begin
         if (fe_cnt_ff == FE_LAST) begin
            fe_cnt_ff <= '0;
            freq_err_ff <= tint_sat - tint_ref_ff;
            tint_ref_ff <= tint_sat;
         end else begin
            fe_cnt_ff <= fe_cnt_ff + 10'h1;
         end
      end
   end

   // health word; each fault owns one bit
   logic [HEALTH_W-1:0] health;

   always_comb begin
      health = '0;
      health[HB_WARMUP] = ~warmup_done;
      health[HB_UNLOCK] = ~osc_loop_locked;
      health[HB_PHASE] = pps_lock_mode & phase_bad_ff;
      health[HB_HOLD] = holdover_active;
      health[HB_EFC] = efc_too_high;
   end

   // control output scaling
   logic signed [DATA_W-1:0] efc_rel_ff;
   logic [DATA_W-1:0] efc_abs_ff;
   logic [EFC_W+7:0] rel_prod;
   logic [EFC_W+12:0] abs_prod;

   assign rel_prod = (EFC_W + 8)'(osc_control_output) * REL_K;
   assign abs_prod = (EFC_W + 13)'(osc_control_output) * ABS_K;

   always_ff @(posedge mclk) begin
      if (rst) begin
         efc_rel_ff <= '0;
         efc_abs_ff <= '0;
      end else if (ce) begin
         efc_rel_ff <= $signed({24'h000000, rel_prod[EFC_W+7:EFC_W]}) -
                       $signed({24'h000000, REL_OFS});
         efc_abs_ff <= DATA_W'(abs_prod[EFC_W+12:EFC_W]);
      end
   end

   // lifetime counter ticks on each wrap of the pulse output timebase
   logic [11:0] hour_sec_ff;
   logic [DATA_W-1:0] hours_ff;

   always_ff @(posedge mclk) begin
      if (rst) begin
         hour_sec_ff <= '0;
         hours_ff <= '0;
      end else if (ce && pps_wrap) begin
         if (hour_sec_ff == HOUR_LAST) begin
            hour_sec_ff <= '0;
            hours_ff <= hours_ff + 1'b1;
         end else begin
            hour_sec_ff <= hour_sec_ff + 12'h001;
         end
      end
   end

   // serial side: echo first, then prompt, then software byte
   logic [7:0] rx_byte_ff, echo_byte_ff, sw_byte_ff;
   logic rx_avail_ff, echo_pend_ff, sw_pend_ff;
   logic [2:0] prompt_left_ff;
   logic tx_go, take_echo, take_prompt, take_sw;

   assign tx_go = ce && !u.tx_busy;
   assign take_echo = tx_go && echo_pend_ff;
   assign take_prompt = tx_go && !echo_pend_ff && (prompt_left_ff != 3'h0);
   assign take_sw = tx_go && !echo_pend_ff && (prompt_left_ff == 3'h0) &&
                    sw_pend_ff;

   always_comb begin
      u.tx_start = take_echo || take_prompt || take_sw;
      if (echo_pend_ff) begin
         u.tx_data = echo_byte_ff;
      end else if (prompt_left_ff != 3'h0) begin
         u.tx_data = prompt_char(PROMPT_LEN - prompt_left_ff);
      end else begin
         u.tx_data = sw_byte_ff;
      end
   end

   assign u.ce = ce;
   assign u.div = baud_div(baud_sel_ff);
   assign u.rx_lvl = rx_lvl_ff;
   assign ser_tx_pin = u.tx_pin;

   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_byte_ff <= 8'h00;
         rx_avail_ff <= 1'b0;
         echo_byte_ff <= 8'h00;
         echo_pend_ff <= 1'b0;
      end else if (ce) begin
         if (u.rx_valid) begin
            rx_byte_ff <= u.rx_data;
            rx_avail_ff <= 1'b1; // arrival beats a same-cycle read
         end else if (rd_rx) begin
            rx_avail_ff <= 1'b0;
         end
         // a byte arriving while one waits replaces it
         if (u.rx_valid && echo_en_ff) begin
            echo_byte_ff <= u.rx_data;
            echo_pend_ff <= 1'b1;
         end else if (take_echo) begin
            echo_pend_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         prompt_left_ff <= 3'h0;
         sw_byte_ff <= 8'h00;
         sw_pend_ff <= 1'b0;
      end else if (ce) begin
         if (u.rx_valid && prompt_en_ff && u.rx_data == CHAR_CR) begin
            prompt_left_ff <= PROMPT_LEN;
         end else if (take_prompt) begin
            prompt_left_ff <= prompt_left_ff - 3'h1;
         end
         if (wr_tx && !sw_pend_ff) begin
            sw_byte_ff <= reg_wdata[7:0];
            sw_pend_ff <= 1'b1;
         end else if (take_sw) begin
            sw_pend_ff <= 1'b0;
         end
      end
   end

   // register reads; data stands for one cycle only
   logic [DATA_W-1:0] rdata_ff;

   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_ff <= '0;
      end else if (ce) begin
         rdata_ff <= '0;
         if (reg_rd) begin
            if (reg_addr == REG_CTRL) begin
               rdata_ff <= DATA_W'({baud_sel_ff, bw_ff, prompt_en_ff,
                                    echo_en_ff, free_run_ff});
            end else if (reg_addr == REG_STATUS) begin
               rdata_ff <= DATA_W'({prompt_left_ff != 3'h0, sw_pend_ff,
                                    rx_avail_ff, sync_st_ff == ST_SYNCED,
                                    sync_st_ff != ST_WAIT,
                                    osc_loop_locked});
            end else if (reg_addr == REG_HEALTH) begin
               rdata_ff <= DATA_W'(health);
            end else if (reg_addr == REG_TINT) begin
               rdata_ff <= tint_ff;
            end else if (reg_addr == REG_FREQ_ERR) begin
               rdata_ff <= freq_err_ff;
            end else if (reg_addr == REG_EFC_REL) begin
               rdata_ff <= efc_rel_ff;
            end else if (reg_addr == REG_EFC_ABS) begin
               rdata_ff <= efc_abs_ff;
            end else if (reg_addr == REG_HOURS) begin
               rdata_ff <= hours_ff;
            end else if (reg_addr == REG_RXDATA) begin
               rdata_ff <= DATA_W'(rx_byte_ff);
            end
         end
      end
   end

   assign reg_rdata = rdata_ff;
endmodule : pshm_top

/* File: dv/pshm_host.sv */
`timescale 1ns/1ps
module pshm_host #(parameter int BIT = 868) (
   input wire logic mclk,
   output logic rx_line,
   input wire logic tx_line
);
   logic [7:0] got;
   initial rx_line = 1'b1;
   // lsb first, stop bit leaves the line at idle high
   task automatic send(input logic [7:0] b);
      for (int i = 0; i < 10; i++) begin
         rx_line <= i == 0 ? 1'b0 : i == 9 ? 1'b1 : b[i-1];
         repeat (BIT) @(posedge mclk);
      end
   endtask : send
   // mid-bit sampling absorbs the integer bit divider
   task automatic recv();
      @(negedge tx_line);
      repeat (BIT / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge mclk);
         got[i] = tx_line;
      end
   endtask : recv
endmodule : pshm_host

/* File: dv/pshm_chk.sv */
`timescale 1ns/1ps
module pshm_chk #(parameter int SEC_CYCLES = 2000) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [pshm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pshm_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic ext_pps_pin,
   input wire logic pps_out,
   input wire logic sentence_trig,
   input wire pshm_pkg::pshm_bw_t fast_osc_loop_bandwidth,
   input wire logic nvm_restore
);
   import pshm_pkg::*;
   logic seen_ff, free_ff;
   logic [1:0] n_ext_ff;
   int gap_ff;
   wire ctrl_wr = reg_wr && reg_addr == REG_CTRL;
   always_ff @(posedge mclk)
      if (rst) seen_ff <= 1'b0;
      else if (ext_pps_pin) seen_ff <= 1'b1;
   always_ff @(posedge mclk)
      if (rst) free_ff <= 1'b0;
      else if (ctrl_wr) free_ff <= reg_wdata[0];
      else if (reg_wr && reg_addr == REG_CMD && reg_wdata[0]) free_ff <= 1'b0;
   // saturates like the design's counter
   always_ff @(posedge mclk)
      if (rst) n_ext_ff <= 2'h0;
      else if ($rose(ext_pps_pin) && ~&n_ext_ff) n_ext_ff <= n_ext_ff + 2'h1;
   always_ff @(posedge mclk)
      if (rst || $rose(pps_out)) gap_ff <= 0;
      else gap_ff <= gap_ff + 1;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence restore_wr_s;
      reg_wr && reg_addr == REG_CMD && reg_wdata[0];
   endsequence
   trig_gate_a: assert property (
      !seen_ff && !free_ff |-> !sentence_trig) else $error("trig gate");
   trig_pulse_a: assert property (
      sentence_trig |=> !sentence_trig) else $error("trig width");
   trig_align_a: assert property (
      $rose(ext_pps_pin) && (free_ff || seen_ff) |-> ##[1:8] sentence_trig)
      else $error("trig align");
   pps_align_a: assert property (
      $rose(ext_pps_pin) && n_ext_ff[1] |-> ##100 pps_out ##[1:8] !pps_out)
      else $error("pps align");
   pps_gap_a: assert property (
      gap_ff <= SEC_CYCLES + 128) else $error("pps stopped");
   bw_reset_a: assert property (
      $past(rst) |-> fast_osc_loop_bandwidth == BW_NARROW) else $error("bw rst");
   bw_keep_a: assert property (
      ctrl_wr && reg_wdata[4:3] == 2'h3 |=> $stable(fast_osc_loop_bandwidth))
      else $error("bw code 3");
   restore_pulse_a: assert property (
      restore_wr_s |-> ##[1:2] nvm_restore) else $error("no restore");
endmodule : pshm_chk
bind pshm_top pshm_chk #(.SEC_CYCLES(SEC_CYCLES)) chk_u (.mclk, .rst,
   .reg_addr, .reg_wdata, .reg_wr, .ext_pps_pin, .pps_out, .sentence_trig,
   .fast_osc_loop_bandwidth, .nvm_restore);

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import pshm_pkg::*;
   localparam int SEC = 2000;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
   logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic ext_pps_pin = 1'b0, warmup_done = 1'b1, osc_loop_locked = 1'b1;
   logic holdover_active = 1'b0, efc_too_high = 1'b0, pps_lock_mode = 1'b0;
   logic ser_rx_pin, ser_tx_pin, pps_out, sentence_trig, nvm_restore, pps_q;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, rdv;
   logic [EFC_W-1:0] osc_control_output = 16'hC000;
   pshm_bw_t fast_osc_loop_bandwidth;
   int n_mismatch = 0, checks = 0, cyc = 0, n_trig = 0, n_pps = 0;
   int trig_t = 0, fall_t = 0, t0, a, b;
   pshm_top #(.SEC_CYCLES(SEC)) dut_u (.mclk, .rst, .ce, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_pps_pin, .ser_rx_pin,
      .ser_tx_pin, .pps_out, .sentence_trig, .warmup_done, .osc_loop_locked,
      .holdover_active, .efc_too_high, .pps_lock_mode, .osc_control_output,
      .fast_osc_loop_bandwidth, .nvm_restore);
   pshm_host host_u (.mclk, .rx_line(ser_rx_pin), .tx_line(ser_tx_pin));
   initial forever #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      pps_q <= pps_out;
      if (sentence_trig === 1'b1) trig_t <= cyc;
      if (sentence_trig === 1'b1) n_trig <= n_trig + 1;
      if (pps_out === 1'b0 && pps_q === 1'b1) fall_t <= cyc;
      if (pps_out === 1'b1 && pps_q === 1'b0) n_pps <= n_pps + 1;
   end
   task automatic end_of_test();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   task automatic wr(input logic [7:0] ad, input logic [31:0] v);
      reg_addr <= ad;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [7:0] ad);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk) rdv = reg_rdata;
   endtask : rd
   task automatic ck(input string n, input logic [7:0] ad,
         input logic [31:0] e);
      rd(ad);
      `CHK(n, e, rdv)
   endtask : ck
   task automatic ext(input int k);
      ext_pps_pin <= 1'b1;
      t0 = cyc;
      repeat (k == 4 ? 110 : 30) @(posedge mclk);
      ext_pps_pin <= 1'b0;
      `CHK("trig_at", 1'b1, trig_t - t0 inside {[0:8]})
   endtask : ext
   initial begin
      repeat (60000) @(posedge mclk);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      ck("ctrl", REG_CTRL, 32'h86);
      ck("unmapped", 8'h30, 32'h0);
      fork
         host_u.send(8'h0D);
         host_u.recv();
      join
      `CHK("echo", 8'h0D, host_u.got)
      ck("rx", REG_RXDATA, 32'h0D);
      `CHK("trig_off", 0, n_trig)
      ck("efc_rel", REG_EFC_REL, 32'h32);
      ck("efc_abs", REG_EFC_ABS, 32'hEA6);
      ck("hours", REG_HOURS, 32'h0);
      ck("status", REG_STATUS, 32'h21);
      ck("health", REG_HEALTH, 32'h0);
      holdover_active <= 1'b1;
      efc_too_high <= 1'b1;
      repeat (4) @(posedge mclk);
      ck("health", REG_HEALTH, 32'h50);
      holdover_active <= 1'b0;
      efc_too_high <= 1'b0;
      wr(REG_CTRL, 32'h96);
      wr(REG_CTRL, 32'hFE);
      ck("ctrl", REG_CTRL, 32'h96);
      `CHK("bw", BW_WIDE, fast_osc_loop_bandwidth)
      wr(REG_CMD, 32'h1);
      ck("ctrl", REG_CTRL, 32'h86);
      wr(REG_CTRL, 32'h87);
      repeat (SEC + 10) @(posedge mclk);
      `CHK("trig_free", 1'b1, n_trig > 0)
      pps_lock_mode <= 1'b1;
      // fourth pulse arrives 30 cycles late
      for (int k = 1; k < 5; k++) begin
         repeat (k == 4 ? SEC : SEC - 30) @(posedge mclk);
         ext(k);
      end
      `CHK("pps_at", 1, fall_t - t0 inside {[100:108]})
      ck("health", REG_HEALTH, 32'h4);
      rd(REG_TINT);
      `CHK("tint", 1'b1, rdv inside {[32'hB54:32'hC1C]})
      a = n_pps;
      b = n_trig;
      repeat (2 * SEC + 50) @(posedge mclk);
      `CHK("pps_run", 1'b1, n_pps >= a + 2)
      `CHK("trig_run", 1'b1, n_trig >= b + 2)
      end_of_test();
   end
endmodule : tb_top
